/* File: vbp_pkg.sv */
package vbp_pkg;

  // address modifier groups (bits 5:3) and accepted sub-codes (bits 2:0)
  localparam logic [2:0] AM_GRP_STD  = 3'h7;
  localparam logic [2:0] AM_GRP_EXT  = 3'h1;
  localparam logic [2:0] AM_SUP_BLK  = 3'h7;
  localparam logic [2:0] AM_SUP_PGM  = 3'h6;
  localparam logic [2:0] AM_SUP_DAT  = 3'h5;
  localparam logic [2:0] AM_NP_BLK   = 3'h3;
  localparam logic [2:0] AM_NP_PGM   = 3'h2;
  localparam logic [2:0] AM_NP_DAT   = 3'h1;

  // address spans of standard and extended cycles
  localparam logic [31:0] A24_SPAN   = 32'h00FFFFFF;
  localparam logic [31:0] A32_SPAN   = 32'hFFFFFFFF;

  localparam logic [1:0]  DS_IDLE    = 2'h3;
  localparam int          NUM_BR     = 4;
  localparam int          IRQ_TOP    = 7;
  localparam int          LANES      = 4;
  localparam int          CLK_PS     = 5000;
  localparam int          PS_PER_NS  = 1000;

  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [3:0]  be;
    logic        write;
    logic        ext;
  } vbp_req_s;

  typedef struct packed {
    logic [31:0] rdata;
    logic        ack;
    logic        err;
  } vbp_rsp_s;

  function automatic logic vbp_am_ok(input logic [5:0] am);
    logic grp_ok;
    logic sub_ok;
    grp_ok = (am[5:3] == AM_GRP_STD) || (am[5:3] == AM_GRP_EXT);
    sub_ok = (am[2:0] == AM_SUP_BLK) || (am[2:0] == AM_SUP_PGM) ||
             (am[2:0] == AM_SUP_DAT) || (am[2:0] == AM_NP_BLK)  ||
             (am[2:0] == AM_NP_PGM)  || (am[2:0] == AM_NP_DAT);
    return grp_ok && sub_ok;
  endfunction : vbp_am_ok

endpackage : vbp_pkg

/* File: vbp_lane_dec.sv */
module vbp_lane_dec
  import vbp_pkg::*;
#(
  parameter int DATA_WIDTH = 32
) (
  // strobes and LWORD select active low as on the bus, A01 active high
  input  wire logic [1:0] ds_n_in,
  input  wire logic       a01_in,
  input  wire logic       lword_n_in,
  // decoded byte selects, bit n is byte(n)
  output logic [3:0]      be_out,
  output logic            ok_out
);

  logic [3:0] sel;
  logic [2:0] cnt;

  if (DATA_WIDTH != 8 && DATA_WIDTH != 16 && DATA_WIDTH != 32) begin : g_chk
    $error("vbp_lane_dec: DATA_WIDTH must be 8, 16 or 32");
  end

  always_comb begin
    sel = {ds_n_in[1], ds_n_in[0], a01_in, lword_n_in};
    case (sel)
      4'h5:    be_out = 4'h1;
      4'h9:    be_out = 4'h2;
      4'h7:    be_out = 4'h4;
      4'hB:    be_out = 4'h8;
      4'h1:    be_out = 4'h3;
      4'h2:    be_out = 4'h6;
      4'h3:    be_out = 4'hC;
      4'h4:    be_out = 4'h7;
      4'h8:    be_out = 4'hE;
      4'h0:    be_out = 4'hF;
      default: be_out = 4'h0;
    endcase
    cnt = 3'({2'h0, be_out[0]} + {2'h0, be_out[1]} +
             {2'h0, be_out[2]} + {2'h0, be_out[3]});
    // narrow ports refuse wider selections
    ok_out = (be_out != 4'h0) && (cnt <= 3'(DATA_WIDTH / 8));
  end

endmodule : vbp_lane_dec

/* File: vbp_slave_port.sv */
// Overview of operation
// - Byte lanes decode from DS1, DS0, A01, LWORD per the lane table.
// - Slave captures the address on the falling edge of the address strobe.
// - Slave answers standard and extended codes alike, ignores short and others.
// - Failed transfer gets bus error; bus timer errors unanswered cycles.
// - Port width 8, 16 or 32 limits bytes moved per cycle.
// - Read data stays driven until both data strobes are high.
// - Acknowledge after write data is taken or read data is driven.
// - Direction is sampled at the first falling data strobe.
// - Granted requester asserts bus busy and owns the bus until release.
// - Bus clear tells the owner to stop at a convenient point.
// - Grant-in is taken if requesting at that level, else passed on.
// - Acknowledge-in is never answered; the adapter does not interrupt, so it is always passed on.
// - Slot one launches the acknowledge chain from the backplane line.
// - Interrupt handler gives level seven the highest priority.
// - System failure is held low from power-up until self-test ends.
module vbp_slave_port
  import vbp_pkg::*;
#(
  parameter int          DATA_WIDTH = 32,
  parameter logic [31:0] A24_BASE   = 32'h00800000,
  parameter logic [31:0] A32_BASE   = 32'h80000000,
  parameter logic [31:0] WIN_MASK   = 32'hFFFF0000,
  parameter int          ARB_LEVEL  = 3,
  parameter bit          SYS_CTRL   = 1'b1,
  parameter int          TIMEOUT_NS = 16000
) (
  // clock and reset
  input  wire logic           clk_in,
  input  wire logic           reset_in,
  // data transfer bus
  input  wire logic [31:1]    a_in,
  input  wire logic [5:0]     am_in,
  input  wire logic           as_n_in,
  input  wire logic [1:0]     ds_n_in,
  input  wire logic           lword_n_in,
  input  wire logic           write_n_in,
  input  wire logic [31:0]    d_in,
  output logic [31:0]         d_out,
  output logic                d_oe_n_out,
  input  wire logic           dtack_n_in,
  output logic                dtack_oe_n_out,
  input  wire logic           berr_n_in,
  output logic                berr_oe_n_out,
  // level driven on every open-drain pin while enabled
  output logic                od_level_out,
  // arbitration bus
  output logic [NUM_BR-1:0]   br_oe_n_out,
  input  wire logic [NUM_BR-1:0] bg_n_in,
  output logic [NUM_BR-1:0]   bg_n_out,
  output logic                bbsy_oe_n_out,
  input  wire logic           bclr_n_in,
  // interrupt bus
  input  wire logic           iack_n_in,
  input  wire logic           iackin_n_in,
  output logic                iackout_n_out,
  input  wire logic [7:1]     irq_n_in,
  output logic [2:0]          irq_level_out,
  // utility bus
  input  wire logic           selftest_done_in,
  output logic                sysfail_oe_n_out,
  // local access side
  output logic                req_valid_out,
  output vbp_req_s            req_out,
  input  wire vbp_rsp_s       rsp_in,
  // local mastership side
  input  wire logic           mst_req_in,
  output logic                mst_own_out,
  output logic                mst_clear_out
);

  localparam int TO_CYC_RAW = TIMEOUT_NS * PS_PER_NS / CLK_PS;
  localparam int TO_CYC     = (TO_CYC_RAW < 1) ? 1 : TO_CYC_RAW;
  localparam int TW         = $clog2(TO_CYC + 1);
  localparam logic [TW-1:0] TO_LAST = TW'(TO_CYC - 1);

  if (ARB_LEVEL < 0 || ARB_LEVEL >= NUM_BR) begin : g_chk
    $error("vbp_slave_port: ARB_LEVEL out of range");
  end

  typedef enum logic [2:0] {S_IDLE, S_ADDR, S_LOCAL, S_DRIVE, S_RESP} vbp_st_e;
  typedef enum logic [1:0] {A_IDLE, A_REQ, A_OWN} vbp_arb_e;

  // slave transfer state
  vbp_st_e     st, next_st;
  logic        as_q, next_as_q;
  logic [31:0] addr_q, next_addr_q;
  logic        ext_q, next_ext_q;
  logic        req_valid, next_req_valid;
  vbp_req_s    req, next_req;
  logic [31:0] d_q, next_d_q;
  logic        d_oe_n, next_d_oe_n;
  logic        dtack_oe_n, next_dtack_oe_n;
  logic        sl_berr, next_sl_berr;
  logic [TW-1:0] tmr, next_tmr;
  logic        tmr_berr, next_tmr_berr;
  logic        berr_oe_n, next_berr_oe_n;
  logic [3:0]  be;
  logic        lane_ok, as_fall, hit, ds_any;
  logic [31:0] a_full;

  vbp_lane_dec #(
    .DATA_WIDTH (DATA_WIDTH)
  ) u_lane (
    .ds_n_in    (ds_n_in),
    .a01_in     (a_in[1]),
    .lword_n_in (lword_n_in),
    .be_out     (be),
    .ok_out     (lane_ok)
  );

  always_comb begin
    a_full  = {a_in, 1'b0};
    as_fall = as_q && !as_n_in;
    ds_any  = (ds_n_in != DS_IDLE);
    hit     = (am_in[5:3] == AM_GRP_STD)
              ? (((a_full ^ A24_BASE) & WIN_MASK & A24_SPAN) == 32'h0)
              : (((a_full ^ A32_BASE) & WIN_MASK & A32_SPAN) == 32'h0);
    next_st         = st;
    next_as_q       = as_n_in;
    next_addr_q     = addr_q;
    next_ext_q      = ext_q;
    next_req_valid  = 1'b0;
    next_req        = req;
    next_d_q        = d_q;
    next_d_oe_n     = d_oe_n;
    next_dtack_oe_n = dtack_oe_n;
    next_sl_berr    = sl_berr;
    case (st)
      S_IDLE: begin
        if (as_fall && vbp_am_ok(am_in) && hit) begin
          next_addr_q = a_full;
          next_ext_q  = (am_in[5:3] == AM_GRP_EXT);
          next_st     = S_ADDR;
        end
      end
      S_ADDR: begin
        if (as_n_in) begin
          next_st = S_IDLE;
        end else if (ds_any) begin
          if (lane_ok) begin
            next_req.addr  = addr_q;
            next_req.ext   = ext_q;
            next_req.be    = be;
            next_req.write = !write_n_in;
            next_req.wdata = d_in;
            next_req_valid = 1'b1;
            next_st        = S_LOCAL;
          end else begin
            next_sl_berr = 1'b1;
            next_st      = S_RESP;
          end
        end
      end
      S_LOCAL: begin
        if (rsp_in.err) begin
          next_sl_berr = 1'b1;
          next_st      = S_RESP;
        end else if (rsp_in.ack && req.write) begin
          next_dtack_oe_n = 1'b0;
          next_st         = S_RESP;
        end else if (rsp_in.ack) begin
          next_d_q    = rsp_in.rdata;
          next_d_oe_n = 1'b0;
          next_st     = S_DRIVE;
        end
      end
      S_DRIVE: begin
        // data settles a cycle before the acknowledge
        next_dtack_oe_n = 1'b0;
        next_st         = S_RESP;
      end
      S_RESP: begin
        if (!ds_any) begin
          next_dtack_oe_n = 1'b1;
          next_sl_berr    = 1'b0;
          next_d_oe_n     = 1'b1;
          next_st         = S_IDLE;
        end
      end
      default: next_st = S_IDLE;
    endcase
    // bus timer: only the system controller runs it
    next_tmr      = tmr;
    next_tmr_berr = tmr_berr;
    if (!SYS_CTRL || !ds_any) begin
      next_tmr      = '0;
      next_tmr_berr = 1'b0;
    end else if (!tmr_berr && dtack_n_in && berr_n_in) begin
      if (tmr == TO_LAST) begin
        next_tmr_berr = 1'b1;
      end else begin
        next_tmr = tmr + TW'(1);
      end
    end
    next_berr_oe_n = !(next_sl_berr || next_tmr_berr);
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      st         <= S_IDLE;
      as_q       <= 1'b1;
      addr_q     <= '0;
      ext_q      <= 1'b0;
      req_valid  <= 1'b0;
      req        <= '0;
      d_q        <= '0;
      d_oe_n     <= 1'b1;
      dtack_oe_n <= 1'b1;
      sl_berr    <= 1'b0;
      tmr        <= '0;
      tmr_berr   <= 1'b0;
      berr_oe_n  <= 1'b1;
    end else begin
      st         <= next_st;
      as_q       <= next_as_q;
      addr_q     <= next_addr_q;
      ext_q      <= next_ext_q;
      req_valid  <= next_req_valid;
      req        <= next_req;
      d_q        <= next_d_q;
      d_oe_n     <= next_d_oe_n;
      dtack_oe_n <= next_dtack_oe_n;
      sl_berr    <= next_sl_berr;
      tmr        <= next_tmr;
      tmr_berr   <= next_tmr_berr;
      berr_oe_n  <= next_berr_oe_n;
    end
  end

  // arbitration, interrupt and utility state
  vbp_arb_e          arb, next_arb;
  logic [NUM_BR-1:0] br_oe_n, next_br_oe_n, bg_n, next_bg_n;
  logic              bbsy_oe_n, next_bbsy_oe_n, clr, next_clr;
  logic              own, next_own;
  logic              iackout_n, next_iackout_n, sysfail_oe_n;
  logic              next_sysfail_oe_n, iack_src;
  logic [2:0]        irq_lvl, next_irq_lvl;

  always_comb begin
    next_arb = arb;
    case (arb)
      A_IDLE:  if (mst_req_in) next_arb = A_REQ;
      // take the grant only while still requesting at our level
      A_REQ:   if (!mst_req_in) next_arb = A_IDLE;
               else if (!bg_n_in[ARB_LEVEL]) next_arb = A_OWN;
      A_OWN:   if (!mst_req_in) next_arb = A_IDLE;
      default: next_arb = A_IDLE;
    endcase
    for (int i = 0; i < NUM_BR; i++) begin
      next_br_oe_n[i] = !(i == ARB_LEVEL && next_arb == A_REQ);
      // hold a grant at our level while requesting, pass all else
      next_bg_n[i] = bg_n_in[i] || (i == ARB_LEVEL && arb != A_IDLE);
    end
    next_bbsy_oe_n = (next_arb != A_OWN);
    next_own       = (next_arb == A_OWN);
    next_clr       = (next_arb == A_OWN) && !bclr_n_in;
    // adapter never interrupts, so every acknowledge passes on
    iack_src       = SYS_CTRL ? iack_n_in : iackin_n_in;
    next_iackout_n = iack_src;
    next_irq_lvl   = 3'h0;
    for (int l = 1; l <= IRQ_TOP; l++) begin
      if (!irq_n_in[l]) next_irq_lvl = 3'(l);
    end
    next_sysfail_oe_n = selftest_done_in && sysfail_oe_n
                        ? 1'b1 : !selftest_done_in ? 1'b0 : 1'b1;
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      arb          <= A_IDLE;
      br_oe_n      <= '1;
      bg_n         <= '1;
      bbsy_oe_n    <= 1'b1;
      own          <= 1'b0;
      clr          <= 1'b0;
      iackout_n    <= 1'b1;
      irq_lvl      <= 3'h0;
      sysfail_oe_n <= 1'b0;
    end else begin
      arb          <= next_arb;
      br_oe_n      <= next_br_oe_n;
      bg_n         <= next_bg_n;
      bbsy_oe_n    <= next_bbsy_oe_n;
      own          <= next_own;
      clr          <= next_clr;
      iackout_n    <= next_iackout_n;
      irq_lvl      <= next_irq_lvl;
      sysfail_oe_n <= next_sysfail_oe_n;
    end
  end

  assign d_out            = d_q;
  assign d_oe_n_out       = d_oe_n;
  assign dtack_oe_n_out   = dtack_oe_n;
  assign berr_oe_n_out    = berr_oe_n;
  assign od_level_out     = 1'b0;
  assign br_oe_n_out      = br_oe_n;
  assign bg_n_out         = bg_n;
  assign bbsy_oe_n_out    = bbsy_oe_n;
  assign iackout_n_out    = iackout_n;
  assign irq_level_out    = irq_lvl;
  assign sysfail_oe_n_out = sysfail_oe_n;
  assign req_valid_out    = req_valid;
  assign req_out          = req;
  assign mst_own_out      = own;
  assign mst_clear_out    = clr;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);

  AST_AM_FILTER: assert property (st == S_IDLE && as_fall
    && !vbp_am_ok(am_in) |=> st == S_IDLE) else $error("bad AM taken");
  AST_LANE_REJECT: assert property (st == S_ADDR && !as_n_in && ds_any
    && !lane_ok |=> !berr_oe_n_out && dtack_oe_n_out && !req_valid_out)
    else $error("bad lane not refused");
  AST_DIR_SAMPLE: assert property (st == S_ADDR && !as_n_in && ds_any
    && lane_ok |=> req_valid_out && req_out.write == !$past(write_n_in))
    else $error("direction not sampled");
  AST_RESP_HOLD: assert property ((!dtack_oe_n_out || !berr_oe_n_out)
    && ds_any |=> (!dtack_oe_n_out || !berr_oe_n_out))
    else $error("response dropped early");
  AST_RELEASE: assert property (st == S_RESP && !ds_any
    |=> dtack_oe_n_out && d_oe_n_out) else $error("response not released");
  AST_READ_ACK: assert property ($fell(dtack_oe_n_out) && !req.write
    |-> !d_oe_n_out && !$past(d_oe_n_out)) else $error("ack before data");
  AST_WRITE_ACK: assert property (st == S_LOCAL && rsp_in.ack
    && !rsp_in.err && req.write |=> !dtack_oe_n_out)
    else $error("write not acked");
  AST_TIMER: assert property (SYS_CTRL && tmr == TO_LAST && ds_any
    && !tmr_berr && dtack_n_in && berr_n_in |=> !berr_oe_n_out)
    else $error("bus timer silent");
  AST_GRANT: assert property (arb == A_REQ && mst_req_in
    && !bg_n_in[ARB_LEVEL] |=> !bbsy_oe_n_out && bg_n_out[ARB_LEVEL])
    else $error("grant not taken");
  AST_PASS: assert property (arb == A_IDLE && !mst_req_in
    && !bg_n_in[ARB_LEVEL] |=> !bg_n_out[ARB_LEVEL])
    else $error("grant not passed");
  AST_BBSY: assert property (!bbsy_oe_n_out && mst_req_in
    |=> !bbsy_oe_n_out) else $error("bus busy dropped");
  AST_CLEAR: assert property (arb == A_OWN && mst_req_in
    && !bclr_n_in |=> mst_clear_out) else $error("bus clear lost");
  AST_IACK: assert property (##1 iackout_n_out ==
    $past(iack_src)) else $error("iack chain");
  AST_IRQ7: assert property (!irq_n_in[7] |=> irq_level_out == 3'h7)
    else $error("level seven not top");
  AST_SYSFAIL: assert property (!selftest_done_in
    |=> !sysfail_oe_n_out) else $error("sysfail released early");

  COV_READ: cover property ($fell(dtack_oe_n_out) && !req.write);
  COV_WRITE: cover property ($fell(dtack_oe_n_out) && req.write);
  COV_TIMEOUT: cover property ($rose(tmr_berr));
  COV_OWN: cover property (arb == A_REQ ##1 arb == A_OWN);

endmodule : vbp_slave_port

/* File: vbp_far_end.sv */
module vbp_far_end (
  // clock
  input  wire logic        clk_in,
  // master-driven transfer lines
  output logic [31:1]      a_out,
  output logic [5:0]       am_out,
  output logic             as_n_out,
  output logic [1:0]       ds_n_out,
  output logic             lword_n_out,
  output logic             write_n_out,
  output logic [31:0]      d_out,
  // resolved wire levels
  input  wire logic [31:0] d_in,
  input  wire logic        dtack_n_in,
  input  wire logic        berr_n_in
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    a_out       = '0;
    am_out      = '0;
    as_n_out    = 1'b1;
    ds_n_out    = 2'h3;
    lword_n_out = 1'b1;
    write_n_out = 1'b1;
    d_out       = '0;
  end

  // one full transfer; answer levels are read where they are settled
  task automatic cycle(input logic [31:0] addr, input logic [5:0] am,
                       input logic [1:0] ds, input logic a01,
                       input logic lw, input logic wr_n,
                       input logic [31:0] wd, output logic [31:0] rd,
                       output logic ack, output logic err);
    int n;
    n = 0;
    ack = 1'b0;
    err = 1'b0;
    rd = '0;
    @(negedge clk_in);
    a_out = {addr[31:2], a01};
    am_out = am;
    lword_n_out = lw;
    write_n_out = wr_n;
    d_out = wr_n ? ~d_out : wd;
    as_n_out = 1'b0;
    @(negedge clk_in);
    ds_n_out = ds;
    while (n < 200 && !ack && !err) begin
      @(negedge clk_in);
      n++;
      ack = (dtack_n_in === 1'b0);
      err = (berr_n_in === 1'b0);
      rd = d_in;
    end
    // released lines show the inverse, never the stale value
    ds_n_out = 2'h3;
    as_n_out = 1'b1;
    d_out = ~d_out;
    n = 0;
    while (n < 200 && (dtack_n_in !== 1'b1 || berr_n_in !== 1'b1)) begin
      @(negedge clk_in);
      n++;
    end
  endtask : cycle
endmodule : vbp_far_end

/* File: vbp_slave_port_bench.sv */
module vbp_slave_port_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import vbp_pkg::*;

  localparam logic [7:0] LANE_TAB [10] = '{8'h51, 8'h92, 8'h74, 8'hB8,
    8'h13, 8'h26, 8'h3C, 8'h47, 8'h8E, 8'h0F};
  localparam logic [5:0] AM_TAB [12] = '{6'h3F, 6'h3E, 6'h3D, 6'h3B,
    6'h3A, 6'h39, 6'h0F, 6'h0E, 6'h0D, 6'h0B, 6'h0A, 6'h09};

  logic clk_in, reset_in, as_n, lword_n, write_n, d_oe_n, dtack_oe_n;
  logic berr_oe_n, od_level, bbsy_oe_n, bclr_n, iack_n, iackout_n;
  logic selftest_done, sysfail_oe_n, req_valid_out, mst_req, mst_own;
  logic mst_clear, ok, er;
  logic [31:1] a;
  logic [5:0] am;
  logic [1:0] ds_n, rsp_mode;
  logic [31:0] fd, d_out, rd, rd_val;
  logic [3:0] br_oe_n, bg_n_in, bg_n_out;
  logic [7:1] irq_n;
  logic [2:0] irq_level;
  vbp_req_s req_out;
  vbp_rsp_s rsp_in;
  int errors, checks_done, req_seen, cycles;
  wire logic dtack_n = dtack_oe_n ? 1'b1 : od_level;
  wire logic berr_n = berr_oe_n ? 1'b1 : od_level;
  wire logic [31:0] d_bus = d_oe_n ? fd : d_out;

  vbp_far_end far (.clk_in(clk_in), .a_out(a), .am_out(am),
    .as_n_out(as_n), .ds_n_out(ds_n), .lword_n_out(lword_n),
    .write_n_out(write_n), .d_out(fd), .d_in(d_bus),
    .dtack_n_in(dtack_n), .berr_n_in(berr_n));

  // short bus timer keeps unanswered cycles brief
  vbp_slave_port #(.TIMEOUT_NS(50)) dut (.clk_in(clk_in),
    .reset_in(reset_in), .a_in(a), .am_in(am), .as_n_in(as_n),
    .ds_n_in(ds_n), .lword_n_in(lword_n), .write_n_in(write_n),
    .d_in(d_bus), .d_out(d_out), .d_oe_n_out(d_oe_n),
    .dtack_n_in(dtack_n), .dtack_oe_n_out(dtack_oe_n),
    .berr_n_in(berr_n), .berr_oe_n_out(berr_oe_n),
    .od_level_out(od_level), .br_oe_n_out(br_oe_n), .bg_n_in(bg_n_in),
    .bg_n_out(bg_n_out), .bbsy_oe_n_out(bbsy_oe_n), .bclr_n_in(bclr_n),
    .iack_n_in(iack_n), .iackin_n_in(1'b1), .iackout_n_out(iackout_n),
    .irq_n_in(irq_n), .irq_level_out(irq_level),
    .selftest_done_in(selftest_done), .sysfail_oe_n_out(sysfail_oe_n),
    .req_valid_out(req_valid_out), .req_out(req_out), .rsp_in(rsp_in),
    .mst_req_in(mst_req), .mst_own_out(mst_own),
    .mst_clear_out(mst_clear));

  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end

  // local side answers each request two cycles late
  always begin
    @(negedge clk_in);
    if (req_valid_out === 1'b1) begin
      req_seen++;
      if (rsp_mode != 2'h0) begin
        @(negedge clk_in);
        rsp_in.rdata = rd_val;
        rsp_in.ack = (rsp_mode == 2'h1);
        rsp_in.err = (rsp_mode == 2'h2);
        @(negedge clk_in);
        rsp_in = '0;
      end
    end
  end

  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      close_out();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(negedge clk_in);
  endtask : cyc

  task automatic t_sysfail;
    cyc(3);
    chk(32'(sysfail_oe_n), 32'h0);
    selftest_done = 1'b1;
    cyc(2);
    chk(32'(sysfail_oe_n), 32'h1);
    $display("test sysfail done");
  endtask : t_sysfail

  task automatic t_am_write;
    logic [31:0] ad;
    int n0;
    for (int i = 0; i < 12; i++) begin
      ad = (AM_TAB[i][5:3] == 3'h1) ? 32'h80000010 : 32'h00800010;
      n0 = req_seen;
      far.cycle(ad, AM_TAB[i], 2'h0, 1'b0, 1'b0, 1'b0, 32'hC0DE0000 + i,
                rd, ok, er);
      chk(32'(ok), 32'h1);
      chk(32'(req_seen - n0), 32'h1);
      chk(req_out.addr, ad);
      chk(req_out.wdata, 32'hC0DE0000 + i);
      chk(32'(req_out.write), 32'h1);
      chk(32'(req_out.ext), 32'(AM_TAB[i][5:3] == 3'h1));
    end
    $display("test am_write done");
  endtask : t_am_write

  task automatic t_read;
    rd_val = 32'hA5C30F96;
    far.cycle(32'h80000020, 6'h09, 2'h0, 1'b0, 1'b0, 1'b1, '0, rd, ok, er);
    chk(rd, 32'hA5C30F96);
    chk(32'(ok), 32'h1);
    chk(32'(req_out.write), 32'h0);
    $display("test read done");
  endtask : t_read

  task automatic t_lanes;
    logic [7:0] e;
    int n0;
    for (int i = 0; i < 10; i++) begin
      e = LANE_TAB[i];
      far.cycle(32'h00800030, 6'h3D, e[7:6], e[5], e[4], 1'b0, 32'h1,
                rd, ok, er);
      chk(32'(req_out.be), 32'(e[3:0]));
    end
    n0 = req_seen;
    far.cycle(32'h00800030, 6'h3D, 2'h2, 1'b1, 1'b0, 1'b0, 32'h1,
              rd, ok, er);
    chk(32'(er), 32'h1);
    chk(32'(req_seen - n0), 32'h0);
    $display("test lanes done");
  endtask : t_lanes

  task automatic t_errors;
    int n0;
    rsp_mode = 2'h2;
    far.cycle(32'h00800040, 6'h39, 2'h0, 1'b0, 1'b0, 1'b0, 32'h5,
              rd, ok, er);
    chk(32'({ok, er}), 32'h1);
    rsp_mode = 2'h1;
    n0 = req_seen;
    // short code and off-window address go unanswered, timer ends them
    far.cycle(32'h00800040, 6'h2D, 2'h0, 1'b0, 1'b0, 1'b0, 32'h5,
              rd, ok, er);
    chk(32'(er), 32'h1);
    far.cycle(32'h40000040, 6'h0D, 2'h0, 1'b0, 1'b0, 1'b1, 32'h5,
              rd, ok, er);
    chk(32'(er), 32'h1);
    chk(32'(req_seen - n0), 32'h0);
    $display("test errors done");
  endtask : t_errors

  task automatic t_arb;
    bg_n_in[3] = 1'b0;
    cyc(2);
    chk(32'(bg_n_out[3]), 32'h0);
    bg_n_in[3] = 1'b1;
    mst_req = 1'b1;
    cyc(2);
    chk(32'(br_oe_n[3]), 32'h0);
    bg_n_in[3] = 1'b0;
    cyc(2);
    chk(32'({bbsy_oe_n, mst_own, bg_n_out[3]}), 32'h3);
    bclr_n = 1'b0;
    cyc(2);
    chk(32'({mst_clear, bbsy_oe_n}), 32'h2);
    bclr_n = 1'b1;
    bg_n_in[3] = 1'b1;
    mst_req = 1'b0;
    cyc(2);
    chk(32'({bbsy_oe_n, mst_own}), 32'h2);
    $display("test arb done");
  endtask : t_arb

  task automatic t_irq;
    for (int l = 7; l >= 1; l--) begin
      irq_n = ~(7'h7F >> (7 - l));
      cyc(2);
      chk(32'(irq_level), 32'(l));
    end
    irq_n = 7'h7F;
    iack_n = 1'b0;
    cyc(2);
    chk(32'({irq_level, iackout_n}), 32'h0);
    iack_n = 1'b1;
    cyc(2);
    chk(32'(iackout_n), 32'h1);
    $display("test irq done");
  endtask : t_irq

  // power return mid-run: request, sysfail and ownership outputs back to their reset levels
  task automatic t_power;
    mst_req = 1'b1;
    cyc(2);
    chk(32'(br_oe_n[3]), 32'h0);
    reset_in = 1'b1;
    cyc(2);
    chk(32'({br_oe_n, sysfail_oe_n, mst_own}), 32'h3C);
    mst_req = 1'b0;
    reset_in = 1'b0;
    cyc(2);
    chk(32'({sysfail_oe_n, bbsy_oe_n}), 32'h3);
    $display("test power done");
  endtask : t_power

  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : close_out

  initial begin
    reset_in = 1'b1;
    bg_n_in = 4'hF;
    bclr_n = 1'b1;
    iack_n = 1'b1;
    irq_n = 7'h7F;
    selftest_done = 1'b0;
    mst_req = 1'b0;
    rsp_in = '0;
    rsp_mode = 2'h1;
    rd_val = '0;
    cyc(10);
    chk(32'({sysfail_oe_n, dtack_oe_n, bbsy_oe_n}), 32'h3);
    cyc(10);
    reset_in = 1'b0;
    t_sysfail();
    t_am_write();
    t_read();
    t_lanes();
    t_errors();
    t_arb();
    t_power();
    t_irq();
    close_out();
  end
endmodule : vbp_slave_port_bench
